// [src/sac_top.sv]
// Summary of operation
// - serial internal clock, polarity low: frame sync high while serial data valid.
// - polarity high: frame sync driven low while serial data valid.
// - external clock read unfinished at next conversion end: drop it, pulse error.
// - top four result pins always carry result bits 15:12 in either port mode.
// - parallel mode uses frame sync and error pins as result bits 10, 11.
// - busy rises at conversion start, falls once result is latched.
// - output drivers enabled only while chip select and read both low.
// - chip select gates the external serial clock; edges outside are ignored.
// - reset returns to reset state and aborts any running conversion.
// - power-down lets the running conversion finish, then blocks conversions.
// - falling edge of convert start puts hold on and begins conversion.
// - low-power mode, fast mode off: start still low at acquisition end starts conversion at once.
// - serial result shifted out most significant bit first from shift register.
// - external clock: update on rising edge, or falling when inverted.
// - serial clock pin drives under internal clocking, listens under external.
`timescale 1ns/1ps
`default_nettype none
module sac_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // conversion control pins
  input wire logic convertStartN,
  input wire logic powerDownIn,
  input wire logic lowPowerSel,
  input wire logic fastModeSel,
  // read port pins
  input wire logic chipSelectN,
  input wire logic readN,
  input wire logic portSelect,
  input wire logic extClockSel,
  input wire logic frameSyncPolarity,
  input wire logic serialClockInvert,
  input wire logic serialClockIn,
  // result from the converter core
  input wire sac_pkg::sac_word_t convResult,
  // output bus
  output logic [sac_pkg::RES_W-1:0] dataPinOut,
  output logic [sac_pkg::RES_W-1:0] dataPinOe,
  // status
  output logic busy,
  output logic sampleHold,
  output logic powerDownState
);
  import sac_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers and edge finding
  // ------------------------------------------------------------
  logic [IN_W-1:0] rawIn;
  logic [IN_W-1:0] syncIn;
  logic [IN_W-1:0] prevIn_r;

  assign rawIn = {fastModeSel, lowPowerSel, serialClockInvert, frameSyncPolarity, extClockSel,
                  portSelect, powerDownIn, serialClockIn, readN, chipSelectN, convertStartN};

  sac_sync #(
    .W(IN_W),
    .RST_VAL(IN_RST_VAL)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(rawIn),
    .dout(syncIn)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevIn_r <= IN_RST_VAL;
    end else begin
      prevIn_r <= syncIn;
    end
  end

  logic cnvFall;
  logic readEn;
  logic readStart;
  logic sclkRise;
  logic sclkFall;
  logic updEdge;
  logic smpEdge;
  logic serialMode;
  logic extClk;
  logic impulseMode;
  logic pdReq;

  assign cnvFall = prevIn_r[IN_CNV] & ~syncIn[IN_CNV];
  assign readEn = ~syncIn[IN_CS] & ~syncIn[IN_RD];
  assign readStart = readEn & ~(~prevIn_r[IN_CS] & ~prevIn_r[IN_RD]);
  assign sclkRise = ~syncIn[IN_CS] & ~prevIn_r[IN_SCLK] & syncIn[IN_SCLK];
  assign sclkFall = ~syncIn[IN_CS] & prevIn_r[IN_SCLK] & ~syncIn[IN_SCLK];
  assign updEdge = syncIn[IN_SINV] ? sclkFall : sclkRise;
  assign smpEdge = syncIn[IN_SINV] ? sclkRise : sclkFall;
  assign serialMode = syncIn[IN_PSEL];
  assign extClk = syncIn[IN_EXT];
  assign impulseMode = syncIn[IN_LOWP] & ~syncIn[IN_FAST];
  assign pdReq = syncIn[IN_PD];

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  sac_state_e state_r;
  sac_state_e state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic hold_r;
  logic hold_nxt;
  logic pdState_r;
  logic pdState_nxt;
  sac_word_t result_r;
  sac_word_t result_nxt;
  logic resultNew_r;
  logic resultNew_nxt;
  logic convDone;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    hold_nxt = hold_r;
    result_nxt = result_r;
    resultNew_nxt = resultNew_r;
    convDone = 1'b0;
    // a consumed result is only marked read when the read really begins
    if (readStart) begin
      resultNew_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (pdReq) begin
          state_nxt = ST_PDOWN;
        end else if (cnvFall) begin
          state_nxt = ST_CONV;
          cnt_nxt = CONV_CYCLES - 8'h01;
          busy_nxt = 1'b1;
          hold_nxt = 1'b1;
        end
      end
      ST_CONV: begin
        if (cnt_r == 8'h00) begin
          convDone = 1'b1;
          busy_nxt = 1'b0;
          hold_nxt = 1'b0;
          result_nxt = convResult;
          resultNew_nxt = 1'b1;
          if (pdReq) begin
            state_nxt = ST_PDOWN;
          end else begin
            state_nxt = ST_ACQ;
            cnt_nxt = ACQ_CYCLES - 8'h01;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_ACQ: begin
        if (pdReq) begin
          state_nxt = ST_PDOWN;
        end else if (cnt_r == 8'h00 && impulseMode && ~syncIn[IN_CNV]) begin
          state_nxt = ST_CONV;
          cnt_nxt = CONV_CYCLES - 8'h01;
          busy_nxt = 1'b1;
          hold_nxt = 1'b1;
        end else if (cnvFall && (~impulseMode || cnt_r == 8'h00)) begin
          state_nxt = ST_CONV;
          cnt_nxt = CONV_CYCLES - 8'h01;
          busy_nxt = 1'b1;
          hold_nxt = 1'b1;
        end else if (cnt_r == 8'h00) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_PDOWN: begin
        if (~pdReq) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    pdState_nxt = (state_nxt == ST_PDOWN);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      pdState_r <= 1'b0;
      result_r <= '0;
      resultNew_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      pdState_r <= pdState_nxt;
      result_r <= result_nxt;
      resultNew_r <= resultNew_nxt;
    end
  end

  // ------------------------------------------------------------
  // serial read control
  // ------------------------------------------------------------
  sac_ser_if ser();

  sac_shifter u_shifter (
    .clk(clk),
    .sys_rst(sys_rst),
    .ser(ser)
  );

  logic intActive_r;
  logic intActive_nxt;
  logic extPending_r;
  logic extPending_nxt;
  logic sclkOut_r;
  logic sclkOut_nxt;
  logic rdErrPulse;

  assign ser.loadWord = result_r;

  always_comb begin
    intActive_nxt = intActive_r;
    extPending_nxt = extPending_r;
    sclkOut_nxt = sclkOut_r;
    rdErrPulse = 1'b0;
    ser.load = 1'b0;
    ser.shift = 1'b0;
    ser.clear = 1'b0;
    if (intActive_r) begin
      // the internal clock runs at half the system clock
      sclkOut_nxt = ~sclkOut_r;
      if (sclkOut_r) begin
        ser.shift = 1'b1;
        if (ser.bitsLeft == 5'h01) begin
          intActive_nxt = 1'b0;
        end
      end
    end
    if (extPending_r) begin
      if (updEdge) begin
        ser.shift = 1'b1;
      end
      if (smpEdge && ser.bitsLeft == 5'h01) begin
        extPending_nxt = 1'b0;
      end
    end
    if (serialMode && readStart && resultNew_r && ~intActive_r && ~extPending_r) begin
      ser.load = 1'b1;
      if (extClk) begin
        extPending_nxt = 1'b1;
      end else begin
        intActive_nxt = 1'b1;
        sclkOut_nxt = 1'b0;
      end
    end
    if (convDone && extPending_r) begin
      extPending_nxt = 1'b0;
      ser.clear = 1'b1;
      ser.load = 1'b0;
      ser.shift = 1'b0;
      rdErrPulse = 1'b1;
    end
    if (~serialMode) begin
      intActive_nxt = 1'b0;
      extPending_nxt = 1'b0;
      sclkOut_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intActive_r <= 1'b0;
      extPending_r <= 1'b0;
      sclkOut_r <= 1'b0;
    end else begin
      intActive_r <= intActive_nxt;
      extPending_r <= extPending_nxt;
      sclkOut_r <= sclkOut_nxt;
    end
  end

  // ------------------------------------------------------------
  // output pins
  // ------------------------------------------------------------
  logic [RES_W-1:0] pinOut_r;
  logic [RES_W-1:0] pinOut_nxt;
  logic [RES_W-1:0] pinOe_r;
  logic [RES_W-1:0] pinOe_nxt;
  logic fsActive;

  assign fsActive = intActive_r & ~extClk;

  always_comb begin
    // shared pins carry bits 10, 11
    pinOut_nxt = result_r;
    pinOe_nxt = readEn ? {RES_W{1'b1}} : {RES_W{1'b0}};
    if (serialMode) begin
      // lower byte belongs to other port logic; kept quiet in serial mode
      pinOut_nxt[PIN_SER_DATA-1:0] = '0;
      pinOe_nxt[PIN_SER_DATA-1:0] = '0;
      pinOut_nxt[PIN_SER_DATA] = ser.msb;
      pinOut_nxt[PIN_SER_CLK] = sclkOut_r;
      pinOe_nxt[PIN_SER_CLK] = readEn & ~extClk;
      pinOut_nxt[PIN_FSYNC] = syncIn[IN_FSPOL] ? ~fsActive : fsActive;
      pinOut_nxt[PIN_RD_ERR] = rdErrPulse & extClk;
    end
    pinOut_nxt[RES_W-1:PIN_FIXED_LO] = result_r[RES_W-1:PIN_FIXED_LO];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut_r <= '0;
      pinOe_r <= '0;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
    end
  end

  assign dataPinOut = pinOut_r;
  assign dataPinOe = pinOe_r;
  assign busy = busy_r;
  assign sampleHold = hold_r;
  assign powerDownState = pdState_r;

endmodule : sac_top
`default_nettype wire

// [include/sac_pkg.sv]
`default_nettype none
package sac_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 1000;
  localparam int ACQ_TIME_NS = 250;
  localparam logic [7:0] CONV_CYCLES = 8'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACQ_CYCLES = 8'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // result word and pin positions
  // ------------------------------------------------------------
  localparam int RES_W = 16;
  localparam logic [4:0] RES_BITS = 5'h10;
  localparam int PIN_SER_DATA = 8;
  localparam int PIN_SER_CLK = 9;
  localparam int PIN_FSYNC = 10;
  localparam int PIN_RD_ERR = 11;
  localparam int PIN_FIXED_LO = 12;

  // ------------------------------------------------------------
  // synchronised input vector
  // ------------------------------------------------------------
  localparam int IN_W = 11;
  localparam int IN_CNV = 0;
  localparam int IN_CS = 1;
  localparam int IN_RD = 2;
  localparam int IN_SCLK = 3;
  localparam int IN_PD = 4;
  localparam int IN_PSEL = 5;
  localparam int IN_EXT = 6;
  localparam int IN_FSPOL = 7;
  localparam int IN_SINV = 8;
  localparam int IN_LOWP = 9;
  localparam int IN_FAST = 10;
  localparam logic [IN_W-1:0] IN_RST_VAL = 11'h007;

  typedef logic [RES_W-1:0] sac_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_ACQ = 2'b10,
    ST_PDOWN = 2'b11
  } sac_state_e;

endpackage : sac_pkg
`default_nettype wire

// [include/sac_ser_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sac_ser_if;
  logic load;
  logic shift;
  logic clear;
  sac_pkg::sac_word_t loadWord;
  logic msb;
  logic [4:0] bitsLeft;
  modport ctrl(output load, output shift, output clear, output loadWord, input msb, input bitsLeft);
  modport shf(input load, input shift, input clear, input loadWord, output msb, output bitsLeft);
endinterface : sac_ser_if
`default_nettype wire

// [src/sac_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw and filtered levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // a level is taken only once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic stable_r;
      logic stable_nxt;
      always_comb begin
        stable_nxt = (s2_r == s3_r) ? s3_r : stable_r;
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_r <= RST_VAL[i];
          s2_r <= RST_VAL[i];
          s3_r <= RST_VAL[i];
          stable_r <= RST_VAL[i];
        end else begin
          s1_r <= din[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          stable_r <= stable_nxt;
        end
      end
      assign dout[i] = stable_r;
    end
  endgenerate

endmodule : sac_sync
`default_nettype wire

// [src/sac_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_shifter (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control from the read logic
  sac_ser_if.shf ser
);
  import sac_pkg::*;

  sac_word_t shreg_r;
  sac_word_t shreg_nxt;
  logic [4:0] count_r;
  logic [4:0] count_nxt;

  always_comb begin
    shreg_nxt = shreg_r;
    count_nxt = count_r;
    if (ser.clear) begin
      shreg_nxt = '0;
      count_nxt = 5'h00;
    end else if (ser.load) begin
      shreg_nxt = ser.loadWord;
      count_nxt = RES_BITS;
    end else if (ser.shift && count_r != 5'h00) begin
      shreg_nxt = {shreg_r[RES_W-2:0], 1'b0};
      count_nxt = count_r - 5'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shreg_r <= '0;
      count_r <= 5'h00;
    end else begin
      shreg_r <= shreg_nxt;
      count_r <= count_nxt;
    end
  end

  assign ser.msb = shreg_r[RES_W-1];
  assign ser.bitsLeft = count_r;

endmodule : sac_shifter
`default_nettype wire

// [verif/sac_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control pins
  input wire logic convertStartN,
  input wire logic powerDownIn,
  input wire logic lowPowerSel,
  input wire logic fastModeSel,
  input wire logic chipSelectN,
  input wire logic readN,
  input wire logic portSelect,
  // outputs
  input wire logic [sac_pkg::RES_W-1:0] dataPinOut,
  input wire logic [sac_pkg::RES_W-1:0] dataPinOe,
  input wire logic busy,
  input wire logic sampleHold,
  input wire logic powerDownState
);
  import sac_pkg::*;
  logic parOn;
  logic serOn;
  assign parOn = dataPinOe[0];
  assign serOn = dataPinOe[PIN_SER_DATA] & ~dataPinOe[0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ------
  // sequences
  // ------
  sequence convRun;
    busy [*8] ##1 busy [*2] ##1 !busy;
  endsequence
  sequence readOn;
    (!chipSelectN && !readN) [*6];
  endsequence
  // power-down and low-power starts follow other paths
  sequence idleStart;
    $fell(convertStartN) && !busy && !powerDownIn && !powerDownState && (fastModeSel || !lowPowerSel);
  endsequence
  AST_BUSY_LEN: assert property ($rose(busy) |-> convRun)
    else $error("busy width wrong");
  AST_HOLD: assert property (sampleHold == busy)
    else $error("hold differs from busy");
  AST_START: assert property (idleStart |-> ##[3:6] $rose(busy))
    else $error("start edge not taken");
  AST_PD_BLOCK: assert property (powerDownState |-> !$rose(busy))
    else $error("conversion in power-down");
  AST_PD_ENTER: assert property ((powerDownIn && !busy) [*7] |-> powerDownState)
    else $error("power-down not entered");
  AST_TOP_OE: assert property (readOn |-> &dataPinOe[15:12])
    else $error("top pins not driven");
  AST_PAR_OE: assert property ((!chipSelectN && !readN && !portSelect) [*6] |-> dataPinOe == 16'hffff)
    else $error("parallel bus not enabled");
  AST_OE_OFF: assert property ((chipSelectN || readN) [*6] |-> dataPinOe == 16'h0000)
    else $error("bus driven without read");
  AST_PAR_HOLD: assert property (!busy && !$past(busy) && !$past(busy, 3) && parOn && $past(parOn) |-> $stable(dataPinOut))
    else $error("result moved between conversions");
  AST_RD_ERR: assert property ($rose(dataPinOut[PIN_RD_ERR]) && serOn |=> !dataPinOut[PIN_RD_ERR])
    else $error("error flag wider than a pulse");
endmodule : sac_props
bind sac_top sac_props u_props (
  .clk, .sys_rst, .convertStartN, .powerDownIn, .lowPowerSel, .fastModeSel, .chipSelectN,
  .readN, .portSelect, .dataPinOut, .dataPinOe, .busy, .sampleHold, .powerDownState
);
`default_nettype wire

// [verif/sac_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  // requests from the bench
  input wire logic go,
  input wire logic inv,
  input wire logic [4:0] nBits,
  // serial pins
  input wire logic sdata,
  output logic sclk,
  // word as read
  output logic [15:0] word,
  output logic done
);
  logic hi = 1'b0;
  // clock rests at sampling level, still between frames
  assign sclk = inv ^ hi;
  initial begin
    word = 16'h0000;
    done = 1'b0;
  end
  always @(posedge go) begin
    done = 1'b0;
    word = 16'h0000;
    for (int i = 0; i < int'(nBits); i++) begin
      if (i > 0) begin
        // update edge, sampling edge half a period on
        hi = 1'b1;
        #400 hi = 1'b0;
      end
      // first bit taken is the msb
      #400 word = {word[14:0], sdata};
    end
    done = 1'b1;
  end
endmodule : sac_host_model
`default_nettype wire

// [verif/sac_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_top_bench;
  import sac_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic convertStartN = 1'b1;
  logic powerDownIn = 1'b0;
  logic lowPowerSel = 1'b0;
  logic fastModeSel = 1'b0;
  logic chipSelectN = 1'b1;
  logic readN = 1'b1;
  logic portSelect = 1'b0;
  logic extClockSel = 1'b0;
  logic frameSyncPolarity = 1'b0;
  logic serialClockInvert = 1'b0;
  logic serialClockIn;
  sac_word_t convResult = 16'h0000;
  logic [RES_W-1:0] dataPinOut;
  logic [RES_W-1:0] dataPinOe;
  logic busy;
  logic sampleHold;
  logic powerDownState;
  logic go = 1'b0;
  logic [4:0] nBits = 5'h10;
  logic [15:0] hostWord;
  logic hostDone;
  int errTotal = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  sac_top uut (.clk, .sys_rst, .convertStartN, .powerDownIn, .lowPowerSel, .fastModeSel, .chipSelectN,
    .readN, .portSelect, .extClockSel, .frameSyncPolarity, .serialClockInvert, .serialClockIn,
    .convResult, .dataPinOut, .dataPinOe, .busy, .sampleHold, .powerDownState);
  sac_host_model host (.go, .inv(serialClockInvert), .nBits, .sdata(dataPinOut[PIN_SER_DATA]),
    .sclk(serialClockIn), .word(hostWord), .done(hostDone));
  // ------
  // helpers
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic giveVerdict();
    if (errTotal == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : giveVerdict
  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 40) begin
      tick(1);
      n++;
    end
    chk("busy", {15'h0, lvl}, {15'h0, busy});
  endtask : waitBusy
  task automatic pulse();
    convertStartN = 1'b0;
    tick(2);
    convertStartN = 1'b1;
  endtask : pulse
  task automatic start(input sac_word_t w);
    convResult = w;
    pulse();
    waitBusy(1'b1);
  endtask : start
  task automatic conv(input sac_word_t w);
    start(w);
    waitBusy(1'b0);
    tick(2);
  endtask : conv
  task automatic readEn(input logic on);
    chipSelectN = ~on;
    readN = ~on;
  endtask : readEn
  task automatic hostRun(input logic [4:0] n);
    int k;
    k = 0;
    nBits = n;
    go = 1'b1;
    tick(1);
    while (!hostDone && k < 200) begin
      tick(1);
      k++;
    end
    go = 1'b0;
  endtask : hostRun
  // ------
  // scenarios
  // ------
  task automatic scParallel(input sac_word_t w);
    portSelect = 1'b0;
    conv(w);
    readEn(1'b1);
    tick(6);
    chk("par_oe", 16'hffff, dataPinOe);
    chk("par_data", w, dataPinOut);
    conv(~w);
    chk("par_next", ~w, dataPinOut);
    readN = 1'b1;
    tick(6);
    chk("par_off", 16'h0000, dataPinOe);
    chipSelectN = 1'b1;
  endtask : scParallel
  task automatic scAbort();
    start(16'h0f0f);
    tick(3);
    sys_rst = 1'b1;
    tick(1);
    chk("rst_busy", 16'h0000, {15'h0, busy});
    sys_rst = 1'b0;
    tick(2);
    chk("rst_idle", 16'h0000, {15'h0, busy});
  endtask : scAbort
  task automatic scPower(input sac_word_t w);
    start(w);
    powerDownIn = 1'b1;
    waitBusy(1'b0);
    tick(2);
    chk("pd_state", 16'h0001, {15'h0, powerDownState});
    pulse();
    tick(10);
    chk("pd_block", 16'h0000, {15'h0, busy});
    readEn(1'b1);
    tick(6);
    chk("pd_data", w, dataPinOut);
    readEn(1'b0);
    powerDownIn = 1'b0;
    tick(8);
  endtask : scPower
  task automatic scLowPower();
    lowPowerSel = 1'b1;
    tick(6);
    convertStartN = 1'b0;
    waitBusy(1'b1);
    waitBusy(1'b0);
    waitBusy(1'b1);
    convertStartN = 1'b1;
    waitBusy(1'b0);
    tick(6);
    chk("lp_rest", 16'h0000, {15'h0, busy});
    lowPowerSel = 1'b0;
    tick(6);
  endtask : scLowPower
  task automatic scSerInt(input logic pol, input sac_word_t w);
    logic [15:0] got;
    logic last;
    int act;
    got = 16'h0000;
    last = 1'b0;
    act = 0;
    portSelect = 1'b1;
    extClockSel = 1'b0;
    frameSyncPolarity = pol;
    conv(w);
    readEn(1'b1);
    repeat (60) begin
      tick(1);
      if (dataPinOe[PIN_FSYNC] === 1'b1 && dataPinOut[PIN_FSYNC] === ~pol) begin
        act++;
        if (dataPinOut[PIN_SER_CLK] === 1'b1 && !last) got = {got[14:0], dataPinOut[PIN_SER_DATA]};
      end
      last = dataPinOut[PIN_SER_CLK];
    end
    chk("sync_len", 16'h0020, 16'(act));
    chk("ser_word", w, got);
    chk("sclk_oe", 16'h0001, {15'h0, dataPinOe[PIN_SER_CLK]});
    chk("top_bits", {w[15:12], 12'h000}, {dataPinOut[15:12], 12'h000});
    readEn(1'b0);
    tick(6);
  endtask : scSerInt
  task automatic scSerExt(input logic inv, input sac_word_t w);
    portSelect = 1'b1;
    extClockSel = 1'b1;
    serialClockInvert = inv;
    conv(w);
    readEn(1'b1);
    tick(8);
    // word is loaded now; clock edges with chip select high must not shift it
    chipSelectN = 1'b1;
    hostRun(5'h04);
    chipSelectN = 1'b0;
    tick(8);
    chk("sclk_in", 16'h0000, {15'h0, dataPinOe[PIN_SER_CLK]});
    hostRun(5'h10);
    chk("ext_word", w, hostWord);
    readEn(1'b0);
    tick(6);
  endtask : scSerExt
  task automatic scRdErr(input sac_word_t w);
    int hits;
    hits = 0;
    conv(w);
    readEn(1'b1);
    tick(8);
    hostRun(5'h04);
    pulse();
    repeat (30) begin
      tick(1);
      if (dataPinOut[PIN_RD_ERR] === 1'b1) hits++;
    end
    chk("rd_err", 16'h0001, 16'(hits));
    readEn(1'b0);
  endtask : scRdErr
  initial begin
    tick(8);
    sys_rst = 1'b0;
    tick(1);
    chk("rst_oe", 16'h0000, dataPinOe);
    scParallel(16'h5ac3);
    scAbort();
    scPower(16'h9e01);
    scLowPower();
    scSerInt(1'b0, 16'hc3a5);
    scSerInt(1'b1, 16'h8001);
    fastModeSel = 1'b1;
    scSerExt(1'b0, 16'h6d2b);
    scSerExt(1'b1, 16'hb4e7);
    scRdErr(16'h1234);
    giveVerdict();
  end
  // the whole run needs about 800 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errTotal++;
      giveVerdict();
    end
  end
endmodule : sac_top_bench
`default_nettype wire
